// ===== pfs_pkg.sv
// Shared constants and types for the program flow sequencer.
// Assumes a 100 MHz core clock and 9-byte instruction frames.
package pfs_pkg;

  // ****************************************************************
  // Instruction codes and field encodings
  // ****************************************************************
  localparam logic [7:0] OP_COMPARE     = 8'h14;
  localparam logic [7:0] OP_JUMP_COND   = 8'h15;
  localparam logic [7:0] OP_JUMP_ALWAYS = 8'h16;
  localparam logic [7:0] OP_CALL        = 8'h17;
  localparam logic [7:0] OP_RETURN      = 8'h18;
  localparam logic [7:0] OP_WAIT        = 8'h1b;

  localparam logic [7:0] WT_TICKS       = 8'h00;
  localparam logic [7:0] WT_POSITION    = 8'h01;
  localparam logic [7:0] WT_HOME_SWITCH = 8'h02;
  localparam logic [7:0] WT_END_SWITCH  = 8'h03;
  localparam logic [7:0] WT_HOMING_DONE = 8'h04;

  localparam logic [7:0] CC_ZERO      = 8'h00;
  localparam logic [7:0] CC_NOT_ZERO  = 8'h01;
  localparam logic [7:0] CC_EQUAL     = 8'h02;
  localparam logic [7:0] CC_NOT_EQUAL = 8'h03;
  localparam logic [7:0] CC_GREATER   = 8'h04;
  localparam logic [7:0] CC_GREATER_EQ = 8'h05;
  localparam logic [7:0] CC_LOWER     = 8'h06;
  localparam logic [7:0] CC_LOWER_EQ  = 8'h07;
  localparam logic [7:0] CC_TIMEOUT   = 8'h08;
  localparam logic [7:0] CC_ALARM     = 8'h09;
  localparam logic [7:0] CC_DEVIATION = 8'h0a;
  localparam logic [7:0] CC_POS_ERROR = 8'h0b;

  localparam logic [31:0] VAL_USE_ACC  = 32'hffffffff;
  localparam logic [31:0] VAL_NO_LIMIT = 32'h00000000;

  // ****************************************************************
  // Sizes, reset values and timing
  // ****************************************************************
  localparam int          RET_DEPTH   = 8;
  localparam int          PC_W        = 32;
  localparam logic [31:0] PC_RESET    = 32'h00000000;
  localparam logic [31:0] PC_STEP     = 32'h00000001;
  localparam int          TICK_PERIOD_MS  = 10;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          TICK_CYCLES_DEF =
    (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  target;
    logic [7:0]  instr;
    logic [7:0]  kind;
    logic [7:0]  motor;
    logic [31:0] value;    // Byte 3 travels first
    logic [7:0]  csum;
  } pfs_frame_t;

  typedef struct packed {
    logic pos_reached;
    logic home_switch;
    logic end_switch_left;
    logic end_switch_right;
    logic homing_done;
  } pfs_axis_t;

  typedef struct packed {
    logic alarm;
    logic deviation;
    logic pos_error;
  } pfs_fault_t;

  typedef struct packed {
    logic zero;
    logic equal;
    logic greater;
    logic lower;
  } pfs_cmp_t;

endpackage

// ===== pfs_prog_model.sv
// Stored program model: offers the frame addressed by the counter.
// Assumes the bench loads mem by hierarchical writes.
`timescale 1ns/1ps
module pfs_prog_model
  import pfs_pkg::*;
(
  input  wire logic            i_core_clk,
  input  wire logic [PC_W-1:0] i_pc,
  output logic                 o_frame_valid,
  output pfs_frame_t           o_frame
);
  // Word: checksum flip mask, instruction, kind, motor, value
  logic [63:0] mem [64] = '{default: 64'h0};
  logic [63:0] wd;
  logic [7:0]  cs;

  // Refresh on the falling edge so a new counter is answered well
  // before the next rising edge; a nonzero mask spoils the checksum
  always @(negedge i_core_clk) begin
    wd = mem[i_pc[5:0]];
    cs = 8'h01 + wd[55:48] + wd[47:40] + wd[39:32] + wd[31:24]
      + wd[23:16] + wd[15:8] + wd[7:0];
    o_frame_valid <= 1'b1;
    o_frame <= {8'h01, wd[55:0], cs ^ wd[63:56]};
  end
endmodule

// ===== pfs_ret_stack.sv
// Return address stack for subroutine calls.
// Assumes the caller never pushes and pops in the same cycle.
`timescale 1ns/1ps
module pfs_ret_stack
  import pfs_pkg::*;
#(
  parameter int DEPTH = RET_DEPTH,
  parameter int WIDTH = PC_W
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic             i_push,
  input  wire logic             i_pop,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic      [WIDTH-1:0] o_rdata,
  output logic                  o_full,
  output logic                  o_empty
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int PW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    ptr_reg;
  logic [PW-1:0]    ptr_next;
  logic [PW-1:0]    ptr_dec;
  logic [WIDTH-1:0] rdata_reg;
  logic [WIDTH-1:0] rdata_next;

  // ****************************************************************
  // Pointer and read data
  // ****************************************************************
  // Overflowing pushes and underflowing pops are dropped here
  always_comb begin
    ptr_dec    = ptr_reg - PW'(1);
    ptr_next   = ptr_reg;
    rdata_next = rdata_reg;
    if (i_push && !o_full) begin
      ptr_next = ptr_reg + PW'(1);
    end else if (i_pop && !o_empty) begin
      ptr_next   = ptr_dec;
      rdata_next = mem[ptr_dec[AW-1:0]];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_reg   <= '0;
      rdata_reg <= '0;
    end else if (i_ce) begin
      ptr_reg   <= ptr_next;
      rdata_reg <= rdata_next;
    end
  end

  // Storage needs no reset; only the pointer says what is valid
  always_ff @(posedge i_core_clk) begin
    if (i_ce && i_push && !o_full) begin
      mem[ptr_reg[AW-1:0]] <= i_wdata;
    end
  end

  assign o_full  = (ptr_reg == PW'(DEPTH));
  assign o_empty = (ptr_reg == '0);
  assign o_rdata = rdata_reg;

endmodule

// ===== pfs_sequencer.sv
// Program flow sequencer: jumps, calls, returns, compare and waits.
// Assumes program memory answers a fetch with one frame for o_pc and
// that motion status and the accumulator are synchronous inputs.
`timescale 1ns/1ps
module pfs_sequencer
  import pfs_pkg::*;
#(
  parameter int AXES        = 1,
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_run,
  input  wire logic        i_frame_valid,
  input  wire pfs_frame_t  i_frame,
  output logic             o_frame_ready,
  output logic [PC_W-1:0]  o_pc,
  output logic             o_pc_update,
  input  wire logic [31:0] i_acc,
  input  wire pfs_axis_t   i_axis [AXES],
  input  wire pfs_fault_t  i_fault,
  input  wire logic        i_clear_errors,
  output logic             o_timeout_error_flag,
  output logic             o_waiting,
  output logic             o_foreign_valid,
  output pfs_frame_t       o_foreign_frame,
  output logic             o_frame_error,
  output pfs_cmp_t         o_cmp_flags
);

  // ****************************************************************
  // State and storage
  // ****************************************************************
  typedef enum logic [4:0] {
    PFS_IDLE  = 5'b00001,
    PFS_FETCH = 5'b00010,
    PFS_EXEC  = 5'b00100,
    PFS_WAIT  = 5'b01000,
    PFS_RET   = 5'b10000
  } pfs_state_t;

  localparam int CW = $clog2(TICK_CYCLES + 1);

  pfs_state_t       state_reg;
  pfs_state_t       state_next;
  pfs_frame_t       frame_reg;
  pfs_frame_t       frame_next;
  logic [PC_W-1:0]  pc_reg;
  logic [PC_W-1:0]  pc_next;
  logic             pc_upd_reg;
  logic             pc_upd_next;
  logic [31:0]      limit_reg;
  logic [31:0]      limit_next;
  logic [31:0]      ticks_reg;
  logic [31:0]      ticks_next;
  logic [CW-1:0]    cyc_reg;
  logic [CW-1:0]    cyc_next;
  logic             tout_reg;
  logic             tout_next;
  pfs_cmp_t         cmp_reg;
  pfs_cmp_t         cmp_next;
  logic             fgn_vld_reg;
  logic             fgn_vld_next;
  pfs_frame_t       fgn_frm_reg;
  pfs_frame_t       fgn_frm_next;
  logic             ferr_reg;
  logic             ferr_next;

  logic             push;
  logic             pop;
  logic [PC_W-1:0]  stk_rdata;
  logic             stk_full;
  logic             stk_empty;
  logic [7:0]       csum_calc;
  logic             csum_ok;
  pfs_axis_t        axis_sel;
  logic             cond_true;
  logic             wait_met;
  logic             tick_strobe;
  logic [31:0]      ticks_inc;

  // ****************************************************************
  // Return stack
  // ****************************************************************
  pfs_ret_stack #(
    .DEPTH (RET_DEPTH),
    .WIDTH (PC_W)
  ) u_stack (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_push     (push),
    .i_pop      (pop),
    .i_wdata    (pc_reg),
    .o_rdata    (stk_rdata),
    .o_full     (stk_full),
    .o_empty    (stk_empty)
  );

  // ****************************************************************
  // Frame decode helpers
  // ****************************************************************
  // Checksum is the modulo 256 sum of the eight leading bytes
  always_comb begin
    csum_calc = frame_reg.target + frame_reg.instr + frame_reg.kind
              + frame_reg.motor + frame_reg.value[31:24]
              + frame_reg.value[23:16] + frame_reg.value[15:8]
              + frame_reg.value[7:0];
    csum_ok   = (csum_calc == frame_reg.csum);
  end

  // Axis selected by the motor field; unknown axes never report
  always_comb begin
    axis_sel = '0;
    for (int a = 0; a < AXES; a++) begin
      if (frame_reg.motor == 8'(a)) begin
        axis_sel = i_axis[a];
      end
    end
  end

  // Conditional jump test against stored compare flags and faults
  always_comb begin
    unique case (frame_reg.kind)
      CC_ZERO:       cond_true = cmp_reg.zero;
      CC_NOT_ZERO:   cond_true = !cmp_reg.zero;
      CC_EQUAL:      cond_true = cmp_reg.equal;
      CC_NOT_EQUAL:  cond_true = !cmp_reg.equal;
      CC_GREATER:    cond_true = cmp_reg.greater;
      CC_GREATER_EQ: cond_true = cmp_reg.greater || cmp_reg.equal;
      CC_LOWER:      cond_true = cmp_reg.lower;
      CC_LOWER_EQ:   cond_true = cmp_reg.lower || cmp_reg.equal;
      CC_TIMEOUT:    cond_true = tout_reg;
      CC_ALARM:      cond_true = i_fault.alarm;
      CC_DEVIATION:  cond_true = i_fault.deviation;
      CC_POS_ERROR:  cond_true = i_fault.pos_error;
      default:       cond_true = 1'b0;    // Unknown codes never jump
    endcase
  end

  // Event test for the wait kinds that watch an axis
  always_comb begin
    unique case (frame_reg.kind)
      WT_POSITION:    wait_met = axis_sel.pos_reached;
      WT_HOME_SWITCH: wait_met = axis_sel.home_switch;
      WT_END_SWITCH:  wait_met = axis_sel.end_switch_left
                              || axis_sel.end_switch_right;
      WT_HOMING_DONE: wait_met = axis_sel.homing_done;
      default:        wait_met = 1'b0;
    endcase
  end

  // Tick prescaler: one strobe every TICK_CYCLES while waiting
  assign tick_strobe = (cyc_reg == CW'(TICK_CYCLES - 1));
  assign ticks_inc   = ticks_reg + 32'h00000001;

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  // All flow effects are decided here; EXEC lasts exactly one cycle
  always_comb begin
    state_next   = state_reg;
    frame_next   = frame_reg;
    pc_next      = pc_reg;
    pc_upd_next  = 1'b0;
    limit_next   = limit_reg;
    ticks_next   = ticks_reg;
    cyc_next     = cyc_reg;
    cmp_next     = cmp_reg;
    fgn_vld_next = 1'b0;
    fgn_frm_next = fgn_frm_reg;
    ferr_next    = 1'b0;
    tout_next    = tout_reg;
    push         = 1'b0;
    pop          = 1'b0;
    if (i_clear_errors) begin
      tout_next = 1'b0;
    end
    unique case (state_reg)
      PFS_IDLE: begin
        // Frames taken while stopped are host commands: forwarded,
        // never allowed to move the program counter
        if (i_frame_valid) begin
          fgn_vld_next = 1'b1;
          fgn_frm_next = i_frame;
        end
        if (i_run) begin
          state_next = PFS_FETCH;
        end
      end
      PFS_FETCH: begin
        if (!i_run) begin
          state_next = PFS_IDLE;
        end else if (i_frame_valid) begin
          frame_next = i_frame;
          state_next = PFS_EXEC;
        end
      end
      PFS_EXEC: begin
        state_next  = i_run ? PFS_FETCH : PFS_IDLE;
        pc_next     = pc_reg + PC_STEP;
        pc_upd_next = 1'b1;
        if (!csum_ok) begin
          // A damaged frame is skipped rather than executed
          ferr_next = 1'b1;
        end else begin
          unique case (frame_reg.instr)
            OP_JUMP_ALWAYS: begin
              pc_next = frame_reg.value;
            end
            OP_JUMP_COND: begin
              if (cond_true) begin
                pc_next = frame_reg.value;
              end
            end
            OP_CALL: begin
              if (!stk_full) begin
                push    = 1'b1;
                pc_next = frame_reg.value;
              end
            end
            OP_RETURN: begin
              if (!stk_empty) begin
                pop         = 1'b1;
                pc_next     = pc_reg;
                pc_upd_next = 1'b0;
                state_next  = PFS_RET;
              end
            end
            OP_COMPARE: begin
              cmp_next.zero    = (i_acc == 32'h00000000);
              cmp_next.equal   = (i_acc == frame_reg.value);
              cmp_next.greater = ($signed(i_acc) >
                                  $signed(frame_reg.value));
              cmp_next.lower   = ($signed(i_acc) <
                                  $signed(frame_reg.value));
            end
            OP_WAIT: begin
              if (frame_reg.kind <= WT_HOMING_DONE) begin
                // Accumulator sign is the program's concern
                limit_next  = (frame_reg.value == VAL_USE_ACC) ?
                              i_acc : frame_reg.value;
                ticks_next  = 32'h00000000;
                cyc_next    = '0;
                pc_next     = pc_reg;
                pc_upd_next = 1'b0;
                state_next  = PFS_WAIT;
              end
            end
            default: begin
              // Arithmetic, motion and the rest execute elsewhere
              fgn_vld_next = 1'b1;
              fgn_frm_next = frame_reg;
            end
          endcase
        end
      end
      PFS_WAIT: begin
        cyc_next = tick_strobe ? '0 : cyc_reg + CW'(1);
        if (tick_strobe) begin
          ticks_next = ticks_inc;
        end
        if (!i_run) begin
          // Stopping abandons the wait; counter stays on the wait
          state_next = PFS_IDLE;
        end else if (frame_reg.kind == WT_TICKS) begin
          if (ticks_reg >= limit_reg) begin
            pc_next     = pc_reg + PC_STEP;
            pc_upd_next = 1'b1;
            state_next  = PFS_FETCH;
          end
        end else if (wait_met) begin
          pc_next     = pc_reg + PC_STEP;
          pc_upd_next = 1'b1;
          state_next  = PFS_FETCH;
        end else if (limit_reg != VAL_NO_LIMIT &&
                     ticks_reg >= limit_reg) begin
          tout_next   = 1'b1;
          pc_next     = pc_reg + PC_STEP;
          pc_upd_next = 1'b1;
          state_next  = PFS_FETCH;
        end
      end
      PFS_RET: begin
        // Popped word is the call's own address; resume one later
        pc_next     = stk_rdata + PC_STEP;
        pc_upd_next = 1'b1;
        state_next  = i_run ? PFS_FETCH : PFS_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer registers
  // ****************************************************************
  // Clock enable low freezes every flop, including the tick prescaler
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= PFS_IDLE;
      frame_reg   <= '0;
      pc_reg      <= PC_RESET;
      pc_upd_reg  <= 1'b0;
      limit_reg   <= '0;
      ticks_reg   <= '0;
      cyc_reg     <= '0;
      tout_reg    <= 1'b0;
      cmp_reg     <= '0;
      fgn_vld_reg <= 1'b0;
      fgn_frm_reg <= '0;
      ferr_reg    <= 1'b0;
    end else if (i_ce) begin
      state_reg   <= state_next;
      frame_reg   <= frame_next;
      pc_reg      <= pc_next;
      pc_upd_reg  <= pc_upd_next;
      limit_reg   <= limit_next;
      ticks_reg   <= ticks_next;
      cyc_reg     <= cyc_next;
      tout_reg    <= tout_next;   // Set is applied after clear: set wins
      cmp_reg     <= cmp_next;
      fgn_vld_reg <= fgn_vld_next;
      fgn_frm_reg <= fgn_frm_next;
      ferr_reg    <= ferr_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Ready is combinational so a frame is taken in the cycle offered
  assign o_frame_ready        = i_ce && ((state_reg == PFS_FETCH) ||
                                         (state_reg == PFS_IDLE));
  assign o_pc                 = pc_reg;
  assign o_pc_update          = pc_upd_reg;
  assign o_timeout_error_flag = tout_reg;
  assign o_waiting            = (state_reg == PFS_WAIT);
  assign o_foreign_valid      = fgn_vld_reg;
  assign o_foreign_frame      = fgn_frm_reg;
  assign o_frame_error        = ferr_reg;
  assign o_cmp_flags          = cmp_reg;

endmodule

// ===== pfs_sequencer_props.sv
// Concurrent checks on the program flow sequencer ports.
// Assumes i_ce stays high while flow instructions run.
`timescale 1ns/1ps
module pfs_sequencer_props
  import pfs_pkg::*;
(
  input wire logic            i_core_clk,
  input wire logic            i_rst_n,
  input wire logic            i_ce,
  input wire logic            i_run,
  input wire logic            i_frame_valid,
  input wire pfs_frame_t      i_frame,
  input wire logic            o_frame_ready,
  input wire logic [PC_W-1:0] o_pc,
  input wire logic            o_pc_update,
  input wire logic            i_clear_errors,
  input wire logic            o_timeout_error_flag,
  input wire logic            o_waiting
);
  // ****************
  // Accepted frame
  // ****************
  logic [7:0] sum;
  logic       take;

  // A bad checksum skips the frame, so only good frames count as taken
  assign sum = i_frame.target + i_frame.instr + i_frame.kind
    + i_frame.motor + i_frame.value[31:24] + i_frame.value[23:16]
    + i_frame.value[15:8] + i_frame.value[7:0];
  assign take = i_ce && i_run && i_frame_valid && o_frame_ready
    && sum == i_frame.csum;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // ****************
  // Properties
  // ****************
  chk_jump_load: assert property (
    o_pc_update && take && i_frame.instr == OP_JUMP_ALWAYS
    |-> ##2 (o_pc_update && o_pc == $past(i_frame.value, 2)))
    else $error("jump target not loaded");
  chk_call_load: assert property (
    o_pc_update && take && i_frame.instr == OP_CALL |-> ##2
    (o_pc_update && (o_pc == $past(i_frame.value, 2)
      || o_pc == $past(o_pc, 2) + PC_STEP)))
    else $error("call gave a wrong counter");
  chk_cond_load: assert property (
    o_pc_update && take && i_frame.instr == OP_JUMP_COND |-> ##2
    (o_pc_update && (o_pc == $past(i_frame.value, 2)
      || o_pc == $past(o_pc, 2) + PC_STEP)))
    else $error("conditional jump gave a wrong counter");
  chk_wait_enter: assert property (
    o_pc_update && take && i_frame.instr == OP_WAIT
      && i_frame.kind <= WT_HOMING_DONE
    |-> ##2 (o_waiting && !o_pc_update))
    else $error("wait not entered");
  chk_wait_refuse: assert property (
    o_waiting |-> !o_frame_ready) else $error("frame accepted in wait");
  chk_pc_stable: assert property (
    !o_pc_update |-> $stable(o_pc)) else $error("counter moved silently");
  chk_flag_keep: assert property (
    o_timeout_error_flag && !i_clear_errors |=> o_timeout_error_flag)
    else $error("timeout flag dropped");
  chk_flag_clear: assert property (
    i_clear_errors && !o_waiting |=> !o_timeout_error_flag)
    else $error("timeout flag not cleared");
  chk_idle_still: assert property (
    !i_run [*4] |-> !o_pc_update) else $error("counter moved while stopped");
endmodule

bind pfs_sequencer pfs_sequencer_props i_pfs_sequencer_props (
  .i_core_clk, .i_rst_n, .i_ce, .i_run, .i_frame_valid, .i_frame,
  .o_frame_ready, .o_pc, .o_pc_update, .i_clear_errors,
  .o_timeout_error_flag, .o_waiting);

// ===== pfs_sequencer_tb_top.sv
// Self-checking bench for the program flow sequencer.
// Assumes pfs_prog_model as stored program; one axis, short ticks.
`timescale 1ns/1ps
module pfs_sequencer_tb_top
  import pfs_pkg::*;
;
  localparam int          TC    = 4;
  localparam logic [11:0] TAKEN = 12'haca;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        run = 1'b0;
  logic        clr = 1'b0;
  logic        valid, upd, ready, waiting, flag, fvalid, ferr, err, fgn;
  logic [31:0] acc = 32'h0;
  logic [31:0] pc;
  pfs_frame_t  frame;
  pfs_frame_t  ffrm;
  pfs_fault_t  fault = '0;
  pfs_cmp_t    cmp;
  pfs_axis_t   axis [1];
  int          miscompares = 0;
  int          check_count = 0;

  always #5 clk = ~clk;
  initial axis[0] = '0;

  pfs_prog_model i_pfs_prog_model (.i_core_clk(clk), .i_pc(pc),
    .o_frame_valid(valid), .o_frame(frame));
  pfs_sequencer #(.AXES(1), .TICK_CYCLES(TC)) i_pfs_sequencer (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_run(run),
    .i_frame_valid(valid), .i_frame(frame), .o_frame_ready(ready),
    .o_pc(pc), .o_pc_update(upd), .i_acc(acc), .i_axis(axis),
    .i_fault(fault), .i_clear_errors(clr), .o_timeout_error_flag(flag),
    .o_waiting(waiting), .o_foreign_valid(fvalid),
    .o_foreign_frame(ffrm), .o_frame_error(ferr), .o_cmp_flags(cmp));

  // ****************
  // Shared tasks
  // ****************
  task automatic expect_eq(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic put(input int a, input logic [7:0] op,
                     input logic [7:0] kd, input logic [31:0] v);
    i_pfs_prog_model.mem[a] = {8'h00, op, kd, 8'h00, v};
  endtask

  // Bounded wait for the next counter write, noting pulses on the way
  task automatic step(input logic [31:0] exp, output int n);
    n = 0;
    err = 1'b0;
    fgn = 1'b0;
    do begin
      @(negedge clk);
      n++;
      err |= ferr;
      fgn |= fvalid;
    end while (upd !== 1'b1 && n < 200);
    expect_eq(pc, exp);
  endtask

  task automatic rst(input logic r);
    rst_n = 1'b0;
    run = r;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
  endtask

  // Every scenario enters its code through a jump at address zero
  task automatic start(input logic [31:0] base);
    int n;
    put(0, OP_JUMP_ALWAYS, 8'h00, base);
    rst(1'b1);
    step(base, n);
  endtask

  // ****************
  // Scenarios
  // ****************
  // Nine chained calls overflow the stack; eight returns unwind it and a ninth underflows
  task automatic t_calls();
    int n;
    for (int k = 0; k < 9; k++) begin
      put(20 + 2 * k, OP_CALL, 8'h00, 32'(22 + 2 * k));
      put(21 + 2 * k, OP_RETURN, 8'h00, 32'h0);
    end
    start(32'd20);
    for (int k = 1; k < 9; k++) step(32'(20 + 2 * k), n);
    step(32'd37, n);
    for (int k = 7; k >= 0; k--) step(32'(21 + 2 * k), n);
    step(32'd22, n);
    $display("call test done");
  endtask

  task automatic t_waits();
    int n;
    put(40, OP_WAIT, WT_TICKS, 32'h3);
    put(41, OP_WAIT, WT_TICKS, VAL_USE_ACC);
    put(42, OP_WAIT, WT_POSITION, VAL_NO_LIMIT);
    put(43, OP_WAIT, WT_HOME_SWITCH, 32'h2);
    put(44, OP_WAIT, WT_END_SWITCH, 32'h0);
    put(45, OP_WAIT, WT_HOMING_DONE, 32'h0);
    put(46, OP_JUMP_COND, CC_TIMEOUT, 32'h3c);
    acc = 32'h2;
    start(32'd40);
    step(32'd41, n);
    expect_eq(n >= 3 * TC && n <= 3 * TC + 6, 1'b1);
    step(32'd42, n);
    expect_eq(n >= 2 * TC && n <= 2 * TC + 6, 1'b1);
    repeat (40) @(negedge clk);
    expect_eq({waiting, pc}, {1'b1, 32'd42});
    axis[0] = 5'b10000;
    step(32'd43, n);
    expect_eq({n <= 3, flag}, 2'b10);
    axis[0] = 5'b00000;
    step(32'd44, n);
    expect_eq({n >= 2 * TC && n <= 2 * TC + 6, flag}, 2'b11);
    axis[0] = 5'b00010;
    step(32'd45, n);
    axis[0] = 5'b00001;
    step(32'd46, n);
    step(32'h3c, n);
    axis[0] = 5'b00000;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
    expect_eq(flag, 1'b0);
    $display("wait test done");
  endtask

  // Accumulator 5 against 7 is lower; alarm and position error set
  task automatic t_conds();
    int n;
    acc = 32'h5;
    fault = 3'b101;
    put(50, OP_COMPARE, 8'h00, 32'h7);
    for (int c = 0; c < 12; c++) begin
      put(51, OP_JUMP_COND, 8'(c), 32'ha);
      start(32'd50);
      step(32'd51, n);
      expect_eq(cmp, 4'b0001);
      step(TAKEN[c] ? 32'ha : 32'd52, n);
    end
    $display("condition test done");
  endtask

  task automatic t_misc();
    int n;
    put(52, OP_JUMP_ALWAYS, 8'h00, 32'h0);
    i_pfs_prog_model.mem[52][63:56] = 8'h01;
    put(53, 8'h05, 8'h00, 32'h0);
    put(54, OP_JUMP_ALWAYS, 8'h00, 32'h38);
    put(56, OP_WAIT, 8'h05, 32'h0);
    start(32'd52);
    step(32'd53, n);
    expect_eq(err, 1'b1);
    step(32'd54, n);
    expect_eq({err, fgn}, 2'b01);
    step(32'h38, n);
    step(32'd57, n);
    expect_eq({n <= 3, waiting}, 2'b10);
    rst(1'b0);
    step(32'h0, n);
    expect_eq({fgn, upd, ffrm.instr}, {2'b10, OP_JUMP_ALWAYS});
    $display("misc test done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    rst(1'b0);
    t_calls();
    t_waits();
    t_conds();
    t_misc();
    conclude();
  end

  // The whole run needs under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule
